/* File: inc/sstf_pkg.sv */
// Constants and types shared by the synchronous fill transmitter.
package sstf_pkg;
	// Clock rate and the program master reset pulse length.
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned MRST_NS = 3000;
	localparam int unsigned MRST_CYC =
		(MRST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned MRST_W = 7;

	// Register byte offsets on the APB.
	localparam logic [7:0] RXST_OFS = 8'h00;
	localparam logic [7:0] PARM_OFS = 8'h04;
	localparam logic [7:0] TXST_OFS = 8'h08;
	localparam logic [7:0] TXBUF_OFS = 8'h0c;

	// Field positions in receive_status_reg.
	localparam int unsigned RXS_SRCH = 0;
	localparam int unsigned RXS_DTR = 1;
	localparam int unsigned RXS_RTS = 2;
	localparam int unsigned RXS_SECTX = 3;
	localparam int unsigned RXS_RING = 8;
	localparam int unsigned RXS_CTS = 9;
	localparam int unsigned RXS_CAR = 10;
	localparam int unsigned RXS_DSR = 11;
	localparam int unsigned RXS_SECRX = 12;

	// Field positions in line_parameter_reg.
	localparam int unsigned PAR_LEN_LSB = 8;
	localparam int unsigned PAR_PEN = 10;
	localparam int unsigned PAR_PODD = 11;
	localparam int unsigned PAR_ISO = 12;

	// Field positions in transmit_status_reg.
	localparam int unsigned TXS_SEND = 0;
	localparam int unsigned TXS_DONE_IE = 1;
	localparam int unsigned TXS_FILL_IE = 2;
	localparam int unsigned TXS_DONE = 7;
	localparam int unsigned TXS_MRST = 8;
	localparam int unsigned TXS_NODATA = 9;
	localparam int unsigned TXS_BUSY = 10;

	// Reset values, character framing and widths.
	localparam logic [7:0] SYNC_RST = 8'hff;
	localparam logic [3:0] LEN_BASE = 4'h5;
	localparam int unsigned FRAME_W = 11;
	localparam int unsigned CNT_W = 4;
	localparam int unsigned N_SYNC_IN = 6;

	// Transmitter sequencing states.
	typedef enum logic [0:0] {
		TX_IDLE,
		TX_RUN
	} sstf_tx_state_t;
endpackage : sstf_pkg

/* File: core/sstf_sync2.sv */
// Two-stage synchroniser for inputs from outside the clock domain.
module sstf_sync2 #(
	parameter int unsigned W = 1
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			meta_r <= '0;
			q_out <= '0;
		end else if (ce_in) begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule : sstf_sync2

/* File: core/sstf_transmitter.sv */
// Synchronous serial transmitter with sync fill, modem lines and APB.
//
// Chosen here: the address map and the APB register port.
module sstf_transmitter (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic tx_clk_in,
	input wire logic ring_in,
	input wire logic clear_send_line_in,
	input wire logic carrier_in,
	input wire logic data_set_ready_in,
	input wire logic supervisory_rx_line_in,
	output logic tx_serial_out,
	output logic dtr_out,
	output logic request_send_line_out,
	output logic supervisory_tx_line_out,
	output logic sync_search_enable_out,
	output logic [sstf_pkg::FRAME_W-4:0] sync_match_char_out,
	output logic irq_out
);
	import sstf_pkg::*;

	logic [N_SYNC_IN-1:0] sin_w;
	logic lclk_s, ring_s, cts_s, car_s, dsr_s, secrx_s;
	logic lclk_d_r;
	logic fall_w;
	logic clr_w;
	logic [MRST_W-1:0] mrst_cnt_r;
	logic acc_w, xfer_w, hit_w, wr_w;
	logic [31:0] rd_w;
	logic rts_r, sectx_r;
	logic [1:0] len_r;
	logic pen_r, podd_r, iso_r;
	logic send_r, tdie_r, fie_r;
	logic [7:0] buf_r;
	logic buf_full_r;
	logic wr_buf_w;
	sstf_tx_state_t state_r;
	logic [FRAME_W-1:0] sh_r;
	logic [CNT_W-1:0] bits_r;
	logic done_r, nodata_r;
	logic bound_w, load_buf_w, load_fill_w, go_idle_w;
	logic [7:0] ld_char_w;
	logic [FRAME_W-1:0] frame_w;

	// Frame a character: data LSB first, parity, optional start and stop.
	function automatic logic [FRAME_W-1:0] sstf_frame(
		input logic [7:0] d, input logic [1:0] lc,
		input logic pe, input logic po, input logic iso);
		logic [FRAME_W-1:0] f;
		logic p;
		int n;
		f = '0;
		p = po;
		n = int'(LEN_BASE) + int'(lc);
		for (int i = 0; i < 8; i++) begin
			if (i < n) begin
				f[i] = d[i];
				p = p ^ d[i];
			end
		end
		if (pe) begin
			f[n] = p;
			n = n + 1;
		end
		if (iso) begin
			f = {f[FRAME_W-2:0], 1'b0};
			f[n + 1] = 1'b1;
		end
		return f;
	endfunction : sstf_frame

	// Number of line bits in one framed character.
	function automatic logic [CNT_W-1:0] sstf_nbits(
		input logic [1:0] lc, input logic pe, input logic iso);
		return LEN_BASE + {2'h0, lc} + {3'h0, pe} + (iso ? 4'h2 : 4'h0);
	endfunction : sstf_nbits

	// Link clock and modem status lines are brought into this domain.
	assign sin_w = {tx_clk_in, ring_in, clear_send_line_in, carrier_in,
		data_set_ready_in, supervisory_rx_line_in};
	sstf_sync2 #(
		.W(N_SYNC_IN)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.d_in(sin_w),
		.q_out({lclk_s, ring_s, cts_s, car_s, dsr_s, secrx_s})
	);

	// Falling link clock edges move the transmit line.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			lclk_d_r <= 1'b0;
		end else if (ce_in) begin
			lclk_d_r <= lclk_s;
		end
	end
	assign fall_w = ce_in & lclk_d_r & ~lclk_s;

	// Program master reset holds the clear for a fixed pulse.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			mrst_cnt_r <= '0;
		end else if (ce_in) begin
			if (wr_w && paddr_in == TXST_OFS && pwdata_in[TXS_MRST]) begin
				mrst_cnt_r <= MRST_W'(MRST_CYC);
			end else if (mrst_cnt_r != '0) begin
				mrst_cnt_r <= mrst_cnt_r - 1'b1;
			end
		end
	end
	assign clr_w = reset_in | (mrst_cnt_r != '0);

	// APB decode; one wait state, no answer while the clear is active.
	assign acc_w = psel_in & penable_in;
	assign xfer_w = ce_in & acc_w & pready_out;
	assign hit_w = paddr_in == RXST_OFS || paddr_in == PARM_OFS ||
		paddr_in == TXST_OFS || paddr_in == TXBUF_OFS;
	assign wr_w = xfer_w & pwrite_in & hit_w;
	assign wr_buf_w = wr_w & (paddr_in == TXBUF_OFS);

	// Read data assembly; reserved bits read as zero.
	always_comb begin
		rd_w = '0;
		case (paddr_in)
			RXST_OFS: begin
				rd_w[RXS_SRCH] = sync_search_enable_out;
				rd_w[RXS_DTR] = dtr_out;
				rd_w[RXS_RTS] = rts_r;
				rd_w[RXS_SECTX] = sectx_r;
				rd_w[RXS_RING] = ring_s;
				rd_w[RXS_CTS] = cts_s;
				rd_w[RXS_CAR] = car_s;
				rd_w[RXS_DSR] = dsr_s;
				rd_w[RXS_SECRX] = secrx_s;
			end
			PARM_OFS: begin
				rd_w[7:0] = sync_match_char_out;
				rd_w[PAR_LEN_LSB +: 2] = len_r;
				rd_w[PAR_PEN] = pen_r;
				rd_w[PAR_PODD] = podd_r;
				rd_w[PAR_ISO] = iso_r;
			end
			TXST_OFS: begin
				rd_w[TXS_SEND] = send_r;
				rd_w[TXS_DONE_IE] = tdie_r;
				rd_w[TXS_FILL_IE] = fie_r;
				rd_w[TXS_DONE] = done_r;
				rd_w[TXS_NODATA] = nodata_r;
				rd_w[TXS_BUSY] = state_r == TX_RUN;
			end
			TXBUF_OFS: rd_w[7:0] = buf_r;
			default: rd_w = '0;
		endcase
	end

	// APB answer registers.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= '0;
		end else if (ce_in) begin
			pready_out <= 1'b0;
			if (acc_w && !pready_out && mrst_cnt_r == '0) begin
				pready_out <= 1'b1;
				pslverr_out <= ~hit_w;
				prdata_out <= (pwrite_in || !hit_w) ? 32'h0 : rd_w;
			end
		end
	end

	// Modem control and receiver control bits.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			sync_search_enable_out <= 1'b0;
			dtr_out <= 1'b0;
			rts_r <= 1'b0;
			sectx_r <= 1'b0;
		end else if (wr_w && paddr_in == RXST_OFS) begin
			sync_search_enable_out <= pwdata_in[RXS_SRCH];
			dtr_out <= pwdata_in[RXS_DTR];
			rts_r <= pwdata_in[RXS_RTS];
			sectx_r <= pwdata_in[RXS_SECTX];
		end
	end

	// Modem line drivers; request to send needs carrier and terminal ready.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			request_send_line_out <= 1'b0;
			supervisory_tx_line_out <= 1'b0;
		end else if (ce_in) begin
			request_send_line_out <= dtr_out & rts_r & car_s;
			supervisory_tx_line_out <= sectx_r;
		end
	end

	// Line parameters and the shared sync character.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			sync_match_char_out <= SYNC_RST;
			len_r <= 2'h0;
			pen_r <= 1'b0;
			podd_r <= 1'b0;
			iso_r <= 1'b0;
		end else if (wr_w && paddr_in == PARM_OFS) begin
			sync_match_char_out <= pwdata_in[7:0];
			len_r <= pwdata_in[PAR_LEN_LSB +: 2];
			pen_r <= pwdata_in[PAR_PEN];
			podd_r <= pwdata_in[PAR_PODD];
			iso_r <= pwdata_in[PAR_ISO];
		end
	end

	// Transmit control bits.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			send_r <= 1'b0;
			tdie_r <= 1'b0;
			fie_r <= 1'b0;
		end else if (wr_w && paddr_in == TXST_OFS) begin
			send_r <= pwdata_in[TXS_SEND];
			tdie_r <= pwdata_in[TXS_DONE_IE];
			fie_r <= pwdata_in[TXS_FILL_IE];
		end
	end

	// Character boundary decisions, taken on a falling link clock edge.
	assign bound_w = fall_w & (state_r == TX_IDLE || bits_r == '0);
	assign load_buf_w = bound_w & send_r & buf_full_r;
	assign load_fill_w = bound_w & send_r & ~buf_full_r &
		(state_r == TX_RUN) & ~iso_r;
	assign go_idle_w = bound_w & ~send_r & (state_r == TX_RUN);
	assign ld_char_w = load_buf_w ? buf_r : sync_match_char_out;
	// The framed character that the next load puts into the shifter.
	assign frame_w = sstf_frame(ld_char_w, len_r, pen_r, podd_r, iso_r);

	// Transmit buffer; a write in the load cycle keeps the new character.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			buf_r <= 8'h0;
			buf_full_r <= 1'b0;
		end else if (wr_buf_w) begin
			buf_r <= pwdata_in[7:0];
			buf_full_r <= 1'b1;
		end else if (load_buf_w) begin
			buf_full_r <= 1'b0;
		end
	end

	// Shift register, bit counter and line; mark when idle or paused.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			state_r <= TX_IDLE;
			sh_r <= '0;
			bits_r <= '0;
			tx_serial_out <= 1'b1;
		end else if (fall_w) begin
			case (state_r)
				TX_IDLE: begin
					if (load_buf_w) begin
						state_r <= TX_RUN;
					end
				end
				TX_RUN: begin
					if (go_idle_w) begin
						state_r <= TX_IDLE;
					end
				end
				default: state_r <= TX_IDLE;
			endcase
			if (load_buf_w || load_fill_w) begin
				sh_r <= frame_w >> 1;
				tx_serial_out <= frame_w[0];
				bits_r <= sstf_nbits(len_r, pen_r, iso_r) - 1'b1;
			end else if (state_r == TX_RUN && bits_r != '0) begin
				tx_serial_out <= sh_r[0];
				sh_r <= sh_r >> 1;
				bits_r <= bits_r - 1'b1;
			end else begin
				tx_serial_out <= 1'b1;
			end
		end
	end

	// Done sets on a buffer load, a buffer write clears it; set wins.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			done_r <= 1'b0;
		end else if (load_buf_w) begin
			done_r <= 1'b1;
		end else if (wr_buf_w) begin
			done_r <= 1'b0;
		end
	end

	// Fill flag; a status read clears only what it has shown.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			nodata_r <= 1'b0;
		end else if (load_fill_w) begin
			nodata_r <= 1'b1;
		end else if (xfer_w && !pwrite_in && paddr_in == TXST_OFS &&
			prdata_out[TXS_NODATA]) begin
			nodata_r <= 1'b0;
		end
	end

	// Bus interrupt request from flags and their enables.
	always_ff @(posedge ref_clk_in) begin
		if (clr_w) begin
			irq_out <= 1'b0;
		end else if (ce_in) begin
			irq_out <= (done_r & tdie_r) | (nodata_r & fie_r);
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	a_sync_all_ones: assert property ($fell(reset_in) |->
		sync_match_char_out == 8'hff)
		else $error("sync character not all ones after reset");
	a_fill_uses_sync: assert property (load_fill_w && !clr_w |=>
		tx_serial_out == $past(sync_match_char_out[0]))
		else $error("fill bit differs from sync character");
	a_char_length: assert property (load_fill_w && !clr_w |=>
		bits_r == 4'(4 + $past(len_r) + $past(pen_r)))
		else $error("fill frame length wrong");
	a_rts_carrier: assert property (ce_in && !car_s |=>
		!request_send_line_out)
		else $error("request to send without carrier");
	a_dtr_drop: assert property (wr_w && paddr_in == RXST_OFS &&
		!pwdata_in[RXS_DTR] |=> !dtr_out ##1 !request_send_line_out)
		else $error("terminal ready did not drop");
	a_idle_mark: assert property (state_r == TX_IDLE && !clr_w |=>
		tx_serial_out || $past(load_buf_w))
		else $error("line not at mark while idle");
	a_done_on_load: assert property (load_buf_w && !clr_w |=>
		done_r ##1 (irq_out == ($past(tdie_r) ||
		($past(nodata_r) && $past(fie_r)))))
		else $error("done flag or its request wrong");
	a_nodata_on_fill: assert property (load_fill_w && !clr_w |=>
		nodata_r)
		else $error("fill flag not set");
	a_nodata_clear: assert property (xfer_w && !pwrite_in &&
		paddr_in == TXST_OFS && prdata_out[TXS_NODATA] &&
		!load_fill_w && !clr_w |=> !nodata_r)
		else $error("status read did not clear fill flag");
	a_write_clears: assert property (wr_buf_w && !load_buf_w &&
		!clr_w |=> !done_r)
		else $error("buffer write left done set");
	a_irq_gate: assert property (ce_in && !clr_w &&
		!(done_r && tdie_r) && !(nodata_r && fie_r) |=> !irq_out)
		else $error("interrupt without enabled flag");

	c_fill_sent: cover property (load_fill_w);
	c_fill_ended: cover property (load_fill_w ##[1:400] load_buf_w);
	c_send_dropped: cover property (go_idle_w);
	c_mrst: cover property (mrst_cnt_r == 7'h1);
endmodule : sstf_transmitter

/* File: verification/sstf_modem.sv */
// Behavioural modem model facing the transmitter's modem lines.
module sstf_modem (
	input wire logic run_in,
	input wire logic dtr_in,
	input wire logic rts_in,
	input wire logic sec_tx_in,
	output logic tx_clk_out,
	output logic ring_out,
	output logic carrier_out,
	output logic cts_out,
	output logic dsr_out,
	output logic sec_rx_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Transmit clock of 400 ns that rests high while no frame is wanted.
	initial begin
		tx_clk_out = 1'b1;
		#37;
		forever begin
			#200;
			tx_clk_out = run_in ? ~tx_clk_out : 1'b1;
		end
	end

	// Ring until answered, then carrier follows terminal ready.
	assign ring_out = ~dtr_in;
	assign carrier_out = dtr_in;
	// Clear to send answers request to send.
	assign cts_out = rts_in;
	// The modem is always powered in this model.
	assign dsr_out = 1'b1;
	// The far station mirrors the supervisory channel.
	assign sec_rx_out = sec_tx_in;
endmodule : sstf_modem

/* File: verification/sync_serial_transmitter_fill_test.sv */
// Self-checking bench for the synchronous fill transmitter.
module sync_serial_transmitter_fill_test;
	timeunit 1ns;
	timeprecision 1ps;
	import sstf_pkg::*;
	logic ref_clk_in, reset_in, psel, penable, pwrite, run, cap;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, e, tx_clk, ring, cts, car, dsr, srx;
	logic txd, dtr, rts, stx, srch, irq;
	logic [7:0] smc;
	logic bq[$];
	int n_mismatch, num_checks, k, t;

	sstf_transmitter u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.ce_in(1'b1), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.tx_clk_in(tx_clk), .ring_in(ring), .clear_send_line_in(cts),
		.carrier_in(car), .data_set_ready_in(dsr),
		.supervisory_rx_line_in(srx), .tx_serial_out(txd), .dtr_out(dtr),
		.request_send_line_out(rts), .supervisory_tx_line_out(stx),
		.sync_search_enable_out(srch), .sync_match_char_out(smc),
		.irq_out(irq));
	sstf_modem u_modem (.run_in(run), .dtr_in(dtr), .rts_in(rts),
		.sec_tx_in(stx), .tx_clk_out(tx_clk), .ring_out(ring),
		.carrier_out(car), .cts_out(cts), .dsr_out(dsr), .sec_rx_out(srx));

	// System clock of 50 ns.
	initial begin
		ref_clk_in = 1'b0;
		forever #25 ref_clk_in = ~ref_clk_in;
	end

	// Watchdog: a hang anywhere counts as a mismatch and ends the run.
	initial begin
		repeat (50000) @(posedge ref_clk_in);
		n_mismatch++;
		final_report();
	end

	// Line bits are taken at each link fall, before the next bit launches.
	always @(negedge tx_clk) if (cap) bq.push_back(txd);

	task automatic final_report;
		$display("TB: checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] g, input logic [31:0] x,
		input string m);
		num_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (pready !== 1'b1 && n < 300);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 300) begin
			n_mismatch++;
			final_report();
		end
	endtask : apb

	task automatic lw(input int n);
		repeat (n) @(negedge tx_clk);
	endtask : lw

	// Character k of width w, counted from the first space on the line.
	function automatic logic [7:0] fb(input int k, input int w);
		int i;
		logic [7:0] v;
		i = 0;
		v = '0;
		while (i < bq.size() && bq[i] !== 1'b0) i++;
		for (int j = 0; j < w; j++)
			v[j] = (i + k * w + j < bq.size()) ? bq[i + k * w + j] : 1'bx;
		return v;
	endfunction : fb

	// Main sequence: registers, handshake, fill stream, stop, parity.
	initial begin
		{psel, penable, pwrite, run, cap} = '0;
		paddr = '0;
		pwdata = '0;
		n_mismatch = 0;
		num_checks = 0;
		reset_in = 1'b1;
		repeat (3) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		apb(0, PARM_OFS, 0);
		chk(r[7:0], SYNC_RST, "sync reset value");
		chk({31'h0, e}, 0, "mapped read without error");
		chk(smc, 8'hff, "match char reset");
		apb(1, PARM_OFS, 32'h0000_0396);
		apb(0, PARM_OFS, 0);
		chk(smc, 8'h96, "match char follows sync");
		apb(1, TXST_OFS, 32'h0000_0100);
		apb(0, PARM_OFS, 0);
		chk(r[7:0], 8'hff, "sync after master reset");
		apb(1, PARM_OFS, 32'h0000_0396);
		apb(0, 8'h10, 0);
		chk({31'h0, e}, 1, "unmapped slverr");
		chk(r, 0, "unmapped read data");
		$display("TB: test registers done");
		apb(0, RXST_OFS, 0);
		chk(r[RXS_RING], 1, "ring seen");
		chk(r[RXS_DSR], 1, "data set ready seen");
		apb(1, RXST_OFS, 32'h0000_000f);
		repeat (8) @(posedge ref_clk_in);
		chk({dtr, rts, stx, srch}, 4'b1111, "handshake outputs");
		apb(0, RXST_OFS, 0);
		chk({r[RXS_SECRX], r[RXS_CAR], r[RXS_CTS]}, 3'b111, "modem in");
		apb(1, RXST_OFS, 32'h0000_0004);
		repeat (8) @(posedge ref_clk_in);
		chk({dtr, rts}, 2'b00, "ready cleared drops line");
		apb(1, RXST_OFS, 32'h0000_0006);
		$display("TB: test handshake done");
		run <= 1'b1;
		cap <= 1'b1;
		apb(1, TXST_OFS, 32'h0000_0003);
		lw(20);
		chk(txd, 1, "no output before first char");
		apb(1, TXBUF_OFS, 32'h0000_005a);
		lw(3);
		chk(irq, 1, "done interrupt");
		apb(0, TXST_OFS, 0);
		chk(r[TXS_DONE], 1, "done at first bit");
		apb(1, TXST_OFS, 32'h0000_0005);
		repeat (2) @(posedge ref_clk_in);
		chk(irq, 0, "done masked");
		k = 0;
		while (irq !== 1'b1 && k < 400) begin
			@(posedge ref_clk_in);
			k++;
		end
		if (k >= 400) begin
			n_mismatch++;
			final_report();
		end
		apb(0, TXST_OFS, 0);
		chk(r[TXS_NODATA], 1, "fill flag set");
		apb(0, TXST_OFS, 0);
		chk(r[TXS_NODATA], 0, "fill flag cleared by read");
		// Poll the flag until five fill syncs have gone out in all.
		t = 0;
		k = 1;
		while (k < 5 && t < 200) begin
			apb(0, TXST_OFS, 0);
			if (r[TXS_NODATA] === 1'b1) k++;
			t++;
		end
		if (t >= 200) begin
			n_mismatch++;
			final_report();
		end
		apb(1, TXBUF_OFS, 32'h0000_003c);
		apb(0, TXST_OFS, 0);
		chk(r[TXS_DONE], 0, "done cleared by write");
		lw(30);
		chk(fb(0, 8), 8'h5a, "first char lsb first");
		chk(fb(1, 8), 8'h96, "fill follows");
		k = 1;
		while (fb(k, 8) === 8'h96 && k < 12) k++;
		chk(k, 6, "five fill syncs before message");
		chk(fb(k, 8), 8'h3c, "message ends fill");
		chk(fb(k + 1, 8), 8'h96, "fill resumes");
		$display("TB: test fill stream done");
		apb(1, TXST_OFS, 32'h0000_0000);
		lw(30);
		chk(txd, 1, "mark after send cleared");
		apb(0, TXST_OFS, 0);
		chk(r[TXS_BUSY], 0, "idle after send cleared");
		apb(1, RXST_OFS, 32'h0000_0000);
		bq.delete();
		apb(1, PARM_OFS, 32'h0000_0c96);
		apb(1, TXST_OFS, 32'h0000_0001);
		apb(1, TXBUF_OFS, 32'h0000_000a);
		lw(20);
		chk(fb(0, 6), 8'h2a, "five bits odd parity");
		// Isochronous: start and stop framing, then a pause at mark.
		apb(1, TXST_OFS, 32'h0000_0000);
		lw(20);
		bq.delete();
		apb(1, PARM_OFS, 32'h0000_1396);
		apb(1, TXST_OFS, 32'h0000_0001);
		apb(1, TXBUF_OFS, 32'h0000_00a5);
		lw(20);
		chk(fb(0, 8), 8'h4a, "start bit then data");
		chk(fb(1, 8), 8'hff, "stop bit then pause at mark");
		$display("TB: test stop and parity done");
		final_report();
	end
endmodule : sync_serial_transmitter_fill_test
